// ---- hdl/assembly_pkg.sv ----
// Shared constants and types for the input assembly packer
package assembly_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_IN = 12;
  localparam int NUM_OUT = 4;
  localparam int IMG_BYTES = 3;

  // ==========================================================================
  // Assembly instance numbers
  localparam logic [15:0] INST_VALUES = 16'h020C;
  localparam logic [15:0] INST_VALUES_HEALTH = 16'h021C;
  localparam logic [15:0] INST_VALUES_STAT = 16'h022C;
  localparam logic [15:0] INST_OUT_STAT = 16'h0243;
  localparam logic [15:0] INST_COMBINED = 16'h025C;

  // ==========================================================================
  // Image sizes in bytes
  localparam logic [1:0] LEN_NONE = 2'h0;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // ==========================================================================
  // Field positions within the image
  localparam int POS_VALUES = 0;
  localparam int POS_STAT_LO = 12;
  localparam int POS_OUT_HEALTH = 14;
  localparam int POS_IN_HEALTH = 15;
  localparam int POS_STAT_HI = 16;
  localparam int POS_OUT_STAT = 0;

  // ==========================================================================
  // Reset values
  localparam logic [23:0] IMG_RESET = 24'h000000;

  // ==========================================================================
  // Types
  typedef enum {
    LAYOUT_NONE,
    LAYOUT_VALUES,
    LAYOUT_VALUES_HEALTH,
    LAYOUT_VALUES_STAT,
    LAYOUT_OUT_STAT,
    LAYOUT_COMBINED
  } layout_t;

  typedef struct packed {
    logic [23:0] bytes;
    logic [1:0] len;
    logic known;
  } image_t;

  typedef struct packed {
    logic [NUM_IN-1:0] inErr;
    logic [NUM_OUT-1:0] outErr;
  } health_t;

endpackage

// ---- hdl/pin_filter.sv ----
// Three-stage pin synchroniser with agreement filter
module pin_filter #(
  parameter int WIDTH = 12
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // ==========================================================================
  // Synchroniser chain
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // ==========================================================================
  // A change counts once stages two and three agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        level[i] <= 1'b0;
      end else if (stage2[i] == stage3[i]) begin
        level[i] <= stage3[i];
      end
    end
  end

endmodule

// ---- hdl/safety_input_assembly_packer.sv ----
// Packs safety input and health state into cyclic input assembly images
module safety_input_assembly_packer
  import assembly_pkg::*;
#(
  parameter int NIN = 12,
  parameter int NOUT = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [NIN-1:0] safetyInPin,
  input wire assembly_pkg::health_t health,
  input wire logic [15:0] instanceSel,
  input wire logic inputOnlyStrap,
  output assembly_pkg::image_t image,
  output logic allInputsHealthy,
  output logic allOutputsHealthy
);

  import assembly_pkg::*;

  logic [NIN-1:0] safetyInValue;
  logic inputOnly;
  logic strapTaken;
  logic [NIN-1:0] inErr;
  logic [NOUT-1:0] outErr;
  logic [15:0] instReg;
  logic next_inHealthy;
  logic next_outHealthy;
  logic [NOUT-1:0] next_outStat;
  logic [NIN-1:0] inStat;
  image_t next_image;

  // ==========================================================================
  // Instance decode
  function automatic layout_t decodeInstance(input logic [15:0] id);
    unique case (id)
      INST_VALUES: decodeInstance = LAYOUT_VALUES;
      INST_VALUES_HEALTH: decodeInstance = LAYOUT_VALUES_HEALTH;
      INST_VALUES_STAT: decodeInstance = LAYOUT_VALUES_STAT;
      INST_OUT_STAT: decodeInstance = LAYOUT_OUT_STAT;
      INST_COMBINED: decodeInstance = LAYOUT_COMBINED;
      default: decodeInstance = LAYOUT_NONE;
    endcase
  endfunction

  // ==========================================================================
  // Input pins
  pin_filter #(
    .WIDTH(NIN)
  ) u_pin_filter (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pinIn(safetyInPin),
    .level(safetyInValue)
  );

  // ==========================================================================
  // Variant strap caught after reset release
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      strapTaken <= 1'b0;
      inputOnly <= 1'b0;
    end else if (!strapTaken) begin
      strapTaken <= 1'b1;
      inputOnly <= inputOnlyStrap;
    end
  end

  // ==========================================================================
  // Request capture
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      inErr <= '0;
      outErr <= '0;
      instReg <= 16'h0000;
    end else begin
      inErr <= health.inErr;
      outErr <= health.outErr;
      instReg <= instanceSel;
    end
  end

  // ==========================================================================
  // Health flags
  always_comb begin
    inStat = ~inErr;
    next_inHealthy = ~|inErr;
    next_outHealthy = ~|outErr & ~inputOnly;
    next_outStat = inputOnly ? '0 : ~outErr;
  end

  // ==========================================================================
  // Image assembly; everything not written stays zero
  always_comb begin
    next_image = '0;
    next_image.known = 1'b1;
    unique case (decodeInstance(instReg))
      LAYOUT_VALUES: begin
        next_image.len = LEN_TWO;
        next_image.bytes[POS_VALUES +: NIN] = safetyInValue;
      end
      LAYOUT_VALUES_HEALTH: begin
        next_image.len = LEN_TWO;
        next_image.bytes[POS_VALUES +: NIN] = safetyInValue;
        next_image.bytes[POS_IN_HEALTH] = next_inHealthy;
      end
      LAYOUT_VALUES_STAT: begin
        next_image.len = LEN_THREE;
        next_image.bytes[POS_VALUES +: NIN] = safetyInValue;
        next_image.bytes[POS_STAT_LO +: 4] = inStat[3:0];
        next_image.bytes[POS_STAT_HI +: 8] = inStat[11:4];
      end
      LAYOUT_OUT_STAT: begin
        next_image.len = LEN_ONE;
        next_image.bytes[POS_OUT_STAT +: NOUT] = next_outStat;
      end
      LAYOUT_COMBINED: begin
        next_image.len = LEN_TWO;
        next_image.bytes[POS_VALUES +: NIN] = safetyInValue;
        next_image.bytes[POS_IN_HEALTH] = next_inHealthy;
        next_image.bytes[POS_OUT_HEALTH] = next_outHealthy;
      end
      LAYOUT_NONE: begin
        next_image.len = LEN_NONE;
        next_image.known = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Output registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      image <= '{bytes: IMG_RESET, len: LEN_NONE, known: 1'b0};
    end else begin
      image <= next_image;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      allInputsHealthy <= 1'b0;
      allOutputsHealthy <= 1'b0;
    end else begin
      allInputsHealthy <= next_inHealthy;
      allOutputsHealthy <= next_outHealthy;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  values_524_a: assert property (
    instReg == INST_VALUES |=> image.len == LEN_TWO
      && image.bytes[11:0] == $past(safetyInValue)
      && image.bytes[23:12] == 12'h000)
    else $error("image 524 layout wrong");

  value_follow_a: assert property (
    instReg == INST_VALUES && $stable(safetyInValue)
      |=> image.bytes[11:0] == $past(safetyInValue, 2))
    else $error("input value bit not passed through");

  health_540_a: assert property (
    instReg == INST_VALUES_HEALTH |=> image.bytes[15] == ~|$past(inErr)
      && image.bytes[14:12] == 3'h0 && image.len == LEN_TWO)
    else $error("image 540 layout wrong");

  in_health_a: assert property (
    rst_b && |health.inErr |=> ##1 !allInputsHealthy)
    else $error("input health set despite error");

  stat_556_a: assert property (
    instReg == INST_VALUES_STAT |=> image.len == LEN_THREE
      && image.bytes[11:0] == $past(safetyInValue))
    else $error("image 556 layout wrong");

  in_status_a: assert property (
    health.inErr[0] && instanceSel == INST_VALUES_STAT
      |=> ##1 image.bytes[12] == 1'b0)
    else $error("input status bit not cleared on error");

  out_579_a: assert property (
    instReg == INST_OUT_STAT |=> image.len == LEN_ONE
      && image.bytes[23:4] == 20'h00000)
    else $error("image 579 layout wrong");

  out_status_a: assert property (
    instReg == INST_OUT_STAT && !inputOnly
      |=> image.bytes[3:0] == ~$past(outErr))
    else $error("output status flags wrong");

  health_604_a: assert property (
    instReg == INST_COMBINED |=> image.bytes[14] == $past(next_outHealthy)
      && image.bytes[13:12] == 2'h0 && image.bytes[23:16] == 8'h00)
    else $error("image 604 layout wrong");

  out_health_a: assert property (
    rst_b && |health.outErr |=> ##1 !allOutputsHealthy)
    else $error("output health set despite error");

  input_only_a: assert property (
    inputOnly && strapTaken |=> !allOutputsHealthy)
    else $error("output health shown on input-only variant");

  stat_split_a: assert property (
    instReg == INST_VALUES_STAT
      |=> {image.bytes[23:16], image.bytes[15:12]} == ~$past(inErr))
    else $error("per-input status placement wrong");

  unused_zero_a: assert property (
    !image.known |-> image.bytes == 24'h000000)
    else $error("unknown instance image not zero");

  cover_combined_c: cover property (
    instReg == INST_COMBINED ##1 image.bytes[15:14] == 2'h3);
  cover_stat_err_c: cover property (
    instReg == INST_VALUES_STAT ##1 image.bytes[23:16] != 8'hFF);
  cover_out_err_c: cover property (
    instReg == INST_OUT_STAT ##1 image.bytes[3:0] == 4'h0);

endmodule

// ---- sim/image_consumer.sv ----
// Safety controller model that takes in the cyclic input images
module image_consumer
  import assembly_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire assembly_pkg::image_t image,
  output logic [11:0] seenValues
);
  timeunit 1ns;
  timeprecision 1ns;
  // =========================================================
  // Takes only the value field, unused bits are ignored
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      seenValues <= 12'h000;
    end else if (image.known && image.len != LEN_ONE) begin
      seenValues <= image.bytes[11:0];
    end
  end
endmodule

// ---- sim/safety_input_assembly_packer_bench.sv ----
// Self-checking bench for the input assembly packer
module safety_input_assembly_packer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import assembly_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] safetyInPin = 12'h000;
  health_t health = '0;
  logic [15:0] instanceSel = 16'h0000;
  logic inputOnlyStrap = 1'b0;
  image_t image;
  logic allInputsHealthy;
  logic allOutputsHealthy;
  logic [11:0] seenValues;
  int num_errors = 0;
  int checks = 0;
  logic [15:0] insts [$] = '{INST_VALUES, INST_VALUES_HEALTH,
    INST_VALUES_STAT, INST_OUT_STAT, INST_COMBINED, 16'h020D};

  safety_input_assembly_packer uut (.sys_clk(sys_clk), .rst_b(rst_b),
    .safetyInPin(safetyInPin), .health(health), .instanceSel(instanceSel),
    .inputOnlyStrap(inputOnlyStrap), .image(image),
    .allInputsHealthy(allInputsHealthy),
    .allOutputsHealthy(allOutputsHealthy));
  image_consumer peer (.sys_clk(sys_clk), .rst_b(rst_b), .image(image),
    .seenValues(seenValues));

  // =========================================================
  // Clock and watchdog
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    summarize();
  end

  // =========================================================
  // Tasks
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic do_reset(logic strap);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    inputOnlyStrap <= strap;
    repeat (5) @(posedge sys_clk);
    #1;
    cmp("reset image", 0, image);
    cmp("reset health", 0, {allInputsHealthy, allOutputsHealthy});
    @(posedge sys_clk);
    rst_b <= 1'b1;
  endtask

  task automatic run_case(logic [15:0] sel, logic [11:0] pv,
    logic [11:0] ie, logic [3:0] oe);
    int v, s, o, ih, oh, b, n, k;
    @(posedge sys_clk);
    instanceSel <= sel;
    safetyInPin <= pv;
    health <= '{ie, oe};
    repeat (8) @(posedge sys_clk);
    #1;
    v = pv;
    s = ~ie & 12'hFFF;
    o = inputOnlyStrap ? 0 : (~oe & 4'hF);
    ih = (ie == 0);
    oh = !inputOnlyStrap && (oe == 0);
    n = 2;
    k = 1;
    case (sel)
      INST_VALUES: b = v;
      INST_VALUES_HEALTH: b = v | ih << 15;
      INST_VALUES_STAT: begin
        b = v | (s & 15) << 12 | (s >> 4) << 16;
        n = 3;
      end
      INST_OUT_STAT: begin
        b = o;
        n = 1;
      end
      INST_COMBINED: b = v | ih << 15 | oh << 14;
      default: begin
        b = 0;
        n = 0;
        k = 0;
      end
    endcase
    cmp("bytes", b, image.bytes);
    cmp("len", n, image.len);
    cmp("known", k, image.known);
    cmp("in health", ih, allInputsHealthy);
    cmp("out health", oh, allOutputsHealthy);
    if (k && n != 1) begin
      cmp("consumer", v, seenValues);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // =========================================================
  // Main sequence
  initial begin
    void'($urandom(2));
    do_reset(1'b0);
    for (int i = 0; i < 6; i++) begin
      run_case(insts[i], 12'hFFF, 12'h000, 4'h0);
      run_case(insts[i], 12'h801, 12'h001, 4'h8);
      run_case(insts[i], 12'h0A5, 12'h800, 4'h1);
      run_case(insts[i], 12'($urandom), 12'($urandom), 4'($urandom));
      $display("Test layout %0d done", i);
    end
    for (int j = 0; j < 10; j++) begin
      run_case(insts[j % 5], 12'($urandom), 12'($urandom), 4'($urandom));
    end
    $display("Test random done");
    do_reset(1'b1);
    run_case(INST_OUT_STAT, 12'h3C3, 12'h000, 4'h0);
    run_case(INST_COMBINED, 12'h3C3, 12'h000, 4'h0);
    run_case(INST_COMBINED, 12'h000, 12'h010, 4'hF);
    $display("Test input-only done");
    summarize();
  end
endmodule
